// [logic/iacp_regs.vh]
`ifndef IACP_REGS_VH
`define IACP_REGS_VH
// ==========================================
// Register offsets
`define IACP_ADDR_W 4
`define IACP_OFF_POL 4'h0
`define IACP_OFF_STATUS 4'h1
`define IACP_OFF_CLEAR 4'h2
`define IACP_OFF_ENABLE 4'h3
`define IACP_OFF_PDMODE 4'h4
`define IACP_OFF_SERVICE 4'h5
`define IACP_OFF_MULT 4'h6
`define IACP_OFF_CORE 4'h7
// ==========================================
// Field positions and widths
`define IACP_POL_W 4
`define IACP_STAT_W 6
`define IACP_ST_NMI 0
`define IACP_ST_EXT_LO 1
`define IACP_ST_ACK 5
`define IACP_PD_W 2
`define IACP_ID_W 4
`define IACP_SEL_W 3
`define IACP_SVC_GO 4
// ==========================================
// Reset values and codes
`define IACP_POL_RST 4'h0
`define IACP_EN_RST 6'h00
`define IACP_PD_RST 2'h0
`define IACP_PD_MODE2 2'h2
`define IACP_PD_MODE3 2'h3
`define IACP_ID_NMI 4'h1
`define IACP_ID_EXT_A 4'h4
// ==========================================
// Timing counts
`define IACP_ACK_CYCLES 2'h1
`endif

// [logic/iacp_edge_detect.v]
`timescale 1ns/10ps
// ==========================================
// Edge detector with selectable active edge
module iacp_edge_detect (
  input wire clk,
  input wire arst_n,
  input wire level_in,
  input wire falling,
  output reg edge_pulse
);
  reg prev;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prev <= 1'b0;
      edge_pulse <= 1'b0;
    end else begin
      prev <= level_in;
      if (falling) begin
        edge_pulse <= prev & ~level_in;
      end else begin
        edge_pulse <= ~prev & level_in;
      end
    end
  end
endmodule

// [logic/iacp_top.v]
`timescale 1ns/10ps
`include "iacp_regs.vh"
module iacp_top #(
  parameter NUM_EXT = 4
) (
  input wire clk,
  input wire arst_n,
  input wire nmi_in,
  input wire ext_irq_in_a,
  input wire ext_irq_in_b,
  input wire ext_irq_in_c,
  input wire ext_irq_in_d,
  input wire clk_mult_sel0,
  input wire clk_mult_sel1,
  input wire clk_mult_sel2,
  input wire core_service,
  input wire [`IACP_ID_W-1:0] core_service_id,
  input wire [`IACP_ADDR_W-1:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  output reg irq_out,
  output reg nmi_pending,
  output reg [NUM_EXT-1:0] ext_pending,
  output reg irq_service_strobe,
  output reg serviced_irq_id_bit3,
  output reg serviced_irq_id_bit2,
  output reg serviced_irq_id_bit1,
  output reg serviced_irq_id_bit0,
  output reg deep_sleep_status_out,
  output reg core_rate_clk_out,
  output reg half_rate_clk_out,
  output reg [`IACP_SEL_W-1:0] clk_mult_code
);
  // ==========================================
  // Registers
  reg [`IACP_POL_W-1:0] ext_irq_polarity_field;
  reg [`IACP_STAT_W-1:0] status;
  reg [`IACP_STAT_W-1:0] enable;
  reg [`IACP_PD_W-1:0] pd_mode;
  reg strap_taken;
  reg half_div;
  reg [`IACP_ID_W-1:0] sw_id;
  reg sw_go;

  wire nmi_edge;
  wire [NUM_EXT-1:0] ext_edge;
  wire [NUM_EXT-1:0] ext_lvl;
  wire [`IACP_SEL_W-1:0] strap;
  wire wr_pol;
  wire wr_clr;
  wire wr_en;
  wire wr_pd;
  wire wr_svc;
  wire svc_now;
  wire [`IACP_ID_W-1:0] svc_id;
  reg [`IACP_STAT_W-1:0] next_status;
  reg [31:0] next_rdata;

  assign ext_lvl = {ext_irq_in_d, ext_irq_in_c, ext_irq_in_b, ext_irq_in_a};
  assign strap = {clk_mult_sel2, clk_mult_sel1, clk_mult_sel0};
  assign wr_pol = reg_wr && (reg_addr == `IACP_OFF_POL);
  assign wr_clr = reg_wr && (reg_addr == `IACP_OFF_CLEAR);
  assign wr_en = reg_wr && (reg_addr == `IACP_OFF_ENABLE);
  assign wr_pd = reg_wr && (reg_addr == `IACP_OFF_PDMODE);
  assign wr_svc = reg_wr && (reg_addr == `IACP_OFF_SERVICE);
  assign svc_now = core_service | sw_go;
  assign svc_id = core_service ? core_service_id : sw_id;

  // ==========================================
  // Edge detection
  iacp_edge_detect u_nmi (
    .clk(clk),
    .arst_n(arst_n),
    .level_in(nmi_in),
    .falling(1'b0),
    .edge_pulse(nmi_edge)
  );

  genvar gi;
  generate
    for (gi = 0; gi < NUM_EXT; gi = gi + 1) begin : g_ext
      iacp_edge_detect u_ext (
        .clk(clk),
        .arst_n(arst_n),
        .level_in(ext_lvl[gi]),
        .falling(ext_irq_polarity_field[gi]),
        .edge_pulse(ext_edge[gi])
      );
    end
  endgenerate

  // ==========================================
  // Sticky status, set wins over clear
  always @* begin
    next_status = status & ~(reg_wdata[`IACP_STAT_W-1:0] & {`IACP_STAT_W{wr_clr}});
    next_status[`IACP_ST_NMI] = next_status[`IACP_ST_NMI] | nmi_edge;
    next_status[`IACP_ST_EXT_LO+NUM_EXT-1:`IACP_ST_EXT_LO] =
      next_status[`IACP_ST_EXT_LO+NUM_EXT-1:`IACP_ST_EXT_LO] | ext_edge;
    next_status[`IACP_ST_ACK] = next_status[`IACP_ST_ACK] | svc_now;
  end

  // ==========================================
  // Register read mux
  always @* begin
    next_rdata = 32'h00000000;
    if (reg_rd) begin
      case (reg_addr)
        `IACP_OFF_POL: next_rdata[`IACP_POL_W-1:0] = ext_irq_polarity_field;
        `IACP_OFF_STATUS: next_rdata[`IACP_STAT_W-1:0] = status;
        `IACP_OFF_ENABLE: next_rdata[`IACP_STAT_W-1:0] = enable;
        `IACP_OFF_PDMODE: next_rdata[`IACP_PD_W-1:0] = pd_mode;
        `IACP_OFF_MULT: next_rdata[`IACP_SEL_W-1:0] = clk_mult_code;
        `IACP_OFF_CORE: next_rdata[`IACP_ID_W:0] = {irq_service_strobe, serviced_irq_id_bit3,
          serviced_irq_id_bit2, serviced_irq_id_bit1, serviced_irq_id_bit0};
        default: next_rdata = 32'h00000000;
      endcase
    end
  end

  // ==========================================
  // Control registers
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ext_irq_polarity_field <= `IACP_POL_RST;
      enable <= `IACP_EN_RST;
      pd_mode <= `IACP_PD_RST;
      status <= {`IACP_STAT_W{1'b0}};
      reg_rdata <= 32'h00000000;
      irq_out <= 1'b0;
      sw_go <= 1'b0;
      sw_id <= {`IACP_ID_W{1'b0}};
    end else begin
      if (wr_pol) begin
        ext_irq_polarity_field <= reg_wdata[`IACP_POL_W-1:0];
      end
      if (wr_en) begin
        enable <= reg_wdata[`IACP_STAT_W-1:0];
      end
      if (wr_pd) begin
        pd_mode <= reg_wdata[`IACP_PD_W-1:0];
      end
      sw_go <= wr_svc & reg_wdata[`IACP_SVC_GO];
      if (wr_svc) begin
        sw_id <= reg_wdata[`IACP_ID_W-1:0];
      end
      status <= next_status;
      reg_rdata <= next_rdata;
      irq_out <= |(next_status & enable);
    end
  end

  // ==========================================
  // Interrupt flags toward the core
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      nmi_pending <= 1'b0;
      ext_pending <= {NUM_EXT{1'b0}};
    end else begin
      nmi_pending <= nmi_edge;
      ext_pending <= ext_edge;
    end
  end

  // ==========================================
  // Acknowledge strobe and identifier
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_service_strobe <= 1'b0;
      serviced_irq_id_bit3 <= 1'b0;
      serviced_irq_id_bit2 <= 1'b0;
      serviced_irq_id_bit1 <= 1'b0;
      serviced_irq_id_bit0 <= 1'b0;
    end else begin
      irq_service_strobe <= svc_now;
      if (svc_now) begin
        serviced_irq_id_bit3 <= svc_id[3];
        serviced_irq_id_bit2 <= svc_id[2];
        serviced_irq_id_bit1 <= svc_id[1];
        serviced_irq_id_bit0 <= svc_id[0];
      end
    end
  end

  // ==========================================
  // Power-down status and clocks
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      deep_sleep_status_out <= 1'b0;
      core_rate_clk_out <= 1'b0;
      half_rate_clk_out <= 1'b0;
      half_div <= 1'b0;
      strap_taken <= 1'b0;
      clk_mult_code <= {`IACP_SEL_W{1'b0}};
    end else begin
      deep_sleep_status_out <= (pd_mode == `IACP_PD_MODE2) ||
        (pd_mode == `IACP_PD_MODE3);
      core_rate_clk_out <= ~core_rate_clk_out;
      half_div <= ~half_div;
      if (half_div) begin
        half_rate_clk_out <= ~half_rate_clk_out;
      end
      if (!strap_taken) begin
        clk_mult_code <= strap;
        strap_taken <= 1'b1;
      end
    end
  end
endmodule

// [bench/iacp_top_assertions.sv]
`timescale 1ns/10ps
// ==========================================
// Port checks
module iacp_chk #(
  parameter NUM_EXT = 4
) (
  input wire clk,
  input wire arst_n,
  input wire nmi_in,
  input wire core_service,
  input wire [3:0] core_service_id,
  input wire reg_wr,
  input wire nmi_pending,
  input wire [NUM_EXT-1:0] ext_pending,
  input wire irq_service_strobe,
  input wire serviced_irq_id_bit3,
  input wire serviced_irq_id_bit2,
  input wire serviced_irq_id_bit1,
  input wire serviced_irq_id_bit0,
  input wire core_rate_clk_out,
  input wire half_rate_clk_out
);
  wire [3:0] id = {serviced_irq_id_bit3, serviced_irq_id_bit2, serviced_irq_id_bit1,
    serviced_irq_id_bit0};
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  chk_nmi_edge: assert property ($rose(nmi_in) |-> ##[1:3] nmi_pending)
    else $error("nmi edge lost");
  chk_nmi_pulse: assert property (nmi_pending |=> !nmi_pending)
    else $error("nmi pending too long");
  chk_ext_pulse: assert property (ext_pending[0] |=> !ext_pending[0])
    else $error("ext pending too long");
  chk_ack_follow: assert property (core_service |=> irq_service_strobe)
    else $error("no acknowledge");
  chk_ack_cause: assert property (irq_service_strobe |-> $past(core_service) || $past(reg_wr, 2))
    else $error("stray acknowledge");
  chk_id_follow: assert property (core_service |=> id == $past(core_service_id))
    else $error("wrong id");
  chk_clk_full: assert property ($past(arst_n) |-> core_rate_clk_out != $past(core_rate_clk_out))
    else $error("full clock stuck");
  chk_clk_half: assert property ($rose(half_rate_clk_out) |=> half_rate_clk_out ##1 !half_rate_clk_out)
    else $error("half clock wrong");
endmodule
bind iacp_top iacp_chk #(.NUM_EXT(NUM_EXT)) u_chk (.clk(clk), .arst_n(arst_n), .nmi_in(nmi_in),
  .core_service(core_service), .core_service_id(core_service_id), .reg_wr(reg_wr),
  .nmi_pending(nmi_pending), .ext_pending(ext_pending), .irq_service_strobe(irq_service_strobe),
  .serviced_irq_id_bit3(serviced_irq_id_bit3), .serviced_irq_id_bit2(serviced_irq_id_bit2),
  .serviced_irq_id_bit1(serviced_irq_id_bit1), .serviced_irq_id_bit0(serviced_irq_id_bit0),
  .core_rate_clk_out(core_rate_clk_out), .half_rate_clk_out(half_rate_clk_out));

// [bench/iacp_irq_src.sv]
`timescale 1ns/10ps
// ==========================================
// Interrupt sources and board straps
module iacp_irq_src #(
  parameter STRAP = 3'h5
) (
  input wire clk,
  input wire [4:0] want,
  output reg [4:0] pins,
  output wire [2:0] strap
);
  initial pins = 5'h00;
  assign strap = STRAP;
  always @(posedge clk) begin
    pins <= want;
  end
endmodule

// [bench/iacp_top_tb_top.sv]
`timescale 1ns/10ps
// ==========================================
// Testbench
module iacp_top_tb_top;
  logic clk = 0, arst_n = 0, svc = 0, wr = 0, rd = 0, rd_d = 0;
  logic [3:0] sid = 0, addr = 0, pol, t;
  logic [31:0] wd = 0;
  logic [4:0] want = 0;
  logic [31:0] q[$];
  logic [3:0] iq[$];
  wire [4:0] pins;
  wire [2:0] strap;
  wire [2:0] mcode;
  wire [31:0] rdata;
  wire irq, strobe, sleep, i3, i2, i1, i0;
  int n_mismatch = 0, n_tests = 0, m;
  always #5 clk = ~clk;
  iacp_irq_src #(.STRAP(3'h5)) src (.clk(clk), .want(want), .pins(pins), .strap(strap));
  iacp_top dut (.clk(clk), .arst_n(arst_n), .nmi_in(pins[4]), .ext_irq_in_a(pins[0]),
    .ext_irq_in_b(pins[1]), .ext_irq_in_c(pins[2]), .ext_irq_in_d(pins[3]),
    .clk_mult_sel0(strap[0]), .clk_mult_sel1(strap[1]), .clk_mult_sel2(strap[2]),
    .core_service(svc), .core_service_id(sid), .reg_addr(addr), .reg_wdata(wd), .reg_wr(wr),
    .reg_rd(rd), .reg_rdata(rdata), .irq_out(irq), .nmi_pending(), .ext_pending(),
    .irq_service_strobe(strobe), .serviced_irq_id_bit3(i3), .serviced_irq_id_bit2(i2),
    .serviced_irq_id_bit1(i1), .serviced_irq_id_bit0(i0), .deep_sleep_status_out(sleep),
    .core_rate_clk_out(), .half_rate_clk_out(), .clk_mult_code(mcode));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task give_verdict;
    if (n_mismatch == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
  endtask
  task rreg(input logic [3:0] a, input logic [31:0] e);
    q.push_back(e);
    @(posedge clk);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
  endtask
  // Result watcher
  always @(posedge clk) begin
    rd_d <= rd;
    if (rd_d) chk(rdata, q.pop_front());
    if (strobe === 1'h1) chk({i3, i2, i1, i0}, iq.pop_front());
  end
  initial begin
    #100000;
    n_mismatch++;
    give_verdict();
  end
  initial begin
    void'($urandom(32'h100F));
    repeat (20) @(posedge clk);
    arst_n <= 1'h1;
    rreg(4'h6, 32'h5);
    chk(mcode, 3'h5);
    rreg(4'hF, 32'h0);
    wreg(4'h3, 32'h3F);
    rreg(4'h3, 32'h3F);
    pol = $urandom;
    wreg(4'h0, {28'h0, pol});
    rreg(4'h0, {28'h0, pol});
    want <= {1'h0, pol};
    repeat (4) @(posedge clk);
    wreg(4'h2, 32'h3F);
    rreg(4'h1, 32'h0);
    want <= {1'h1, ~pol};
    repeat (5) @(posedge clk);
    chk(irq, 1'h1);
    rreg(4'h1, 32'h1F);
    wreg(4'h2, 32'h1F);
    repeat (4) @(posedge clk);
    rreg(4'h1, 32'h0);
    chk(irq, 1'h0);
    wreg(4'h3, 32'h0);
    want <= {1'h0, pol};
    repeat (2) @(posedge clk);
    want <= {1'h1, pol};
    repeat (5) @(posedge clk);
    chk(irq, 1'h0);
    rreg(4'h1, 32'h1);
    wreg(4'h3, 32'h1);
    repeat (2) @(posedge clk);
    chk(irq, 1'h1);
    wreg(4'h2, 32'h1);
    repeat (2) @(posedge clk);
    chk(irq, 1'h0);
    for (m = 0; m < 8; m++) begin
      t = $urandom;
      iq.push_back(t);
      sid <= t;
      svc <= 1'h1;
      @(posedge clk);
    end
    svc <= 1'h0;
    iq.push_back(4'hA);
    wreg(4'h5, 32'h1A);
    repeat (3) @(posedge clk);
    rreg(4'h1, 32'h20);
    for (m = 0; m < 4; m++) begin
      wreg(4'h4, m);
      repeat (2) @(posedge clk);
      chk(sleep, m >= 2);
    end
    repeat (3) @(posedge clk);
    give_verdict();
  end
endmodule
